// ===== rtl/can_tx_ctrl.sv
// transmit abort, error counting and bit timing with an apb register port
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module can_tx_ctrl
  import can_tx_pkg::*;
#(
  parameter int NUM_BUFS = 3
) (
  // apb
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // protocol engine
  input  wire logic                tx_active,
  input  wire logic [1:0]          tx_buf,
  input  wire logic                tx_success,
  input  wire logic                tx_lost_arb,
  input  wire logic                ack_error,
  input  wire logic                form_error,
  input  wire logic                bit_error,
  input  wire logic                bus_idle,
  output logic      [NUM_BUFS-1:0] tx_pending,
  // bus
  input  wire logic                rx_level,
  output logic                     sample_valid,
  output logic                     sample_bit,
  output logic                     bit_start,
  // status
  output logic                     tx_irq,
  output logic                     err_irq,
  output logic                     bus_off
);
  logic [7:0]          cfg1;
  logic [10:0]         cfg2;
  logic [NUM_BUFS-1:0] req;
  logic [NUM_BUFS-1:0] abt;
  logic [NUM_BUFS-1:0] larb;
  logic [NUM_BUFS-1:0] fault;
  logic [NUM_BUFS-1:0] abort_pend;
  logic [NUM_BUFS-1:0] done;
  logic [8:0]          tec;
  logic [8:0]          next_tec;
  logic                sum_flag;
  logic                warn_flag;
  logic                pass_flag;
  logic                boff_flag;
  err_state_t          err_state;
  logic                wr_en;
  logic [31:0]         read_word;
  logic                addr_ok;
  logic                any_err;

  // ---------------- apb slave: one wait state, answer from flops
  assign wr_en = psel && penable && pready && pwrite;

  always_comb
  begin
    read_word = 32'h0;
    addr_ok   = 1'b1;
    case (paddr)
      ADDR_CTRL: read_word[CTRL_ABORT_ALL_BIT] = |abort_pend;
      ADDR_INTF:
      begin
        read_word[INTF_DONE_LSB +: NUM_BUFS] = done;
        read_word[INTF_ERR_SUM_BIT] = sum_flag;
        read_word[INTF_TX_WARN_BIT] = warn_flag;
        read_word[INTF_TX_PASS_BIT] = pass_flag;
        read_word[INTF_BUS_OFF_BIT] = boff_flag;
      end
      ADDR_CFG1: read_word[7:0] = cfg1;
      ADDR_CFG2: read_word[10:0] = cfg2;
      ADDR_TEC:  read_word[8:0] = tec;
      default:
      begin
        addr_ok = 1'b0;
        for (int i = 0; i < NUM_BUFS; i++)
        begin
          if (paddr == ADDR_TXCON0 + 8'(4 * i))
          begin
            addr_ok = 1'b1;
            read_word[TXCON_REQ_BIT]    = req[i];
            read_word[TXCON_FAULT_BIT]  = fault[i];
            read_word[TXCON_LARB_BIT]   = larb[i];
            read_word[TXCON_ABT_BIT]    = abt[i];
            read_word[TXCON_ACTIVE_BIT] = tx_active && (tx_buf == 2'(i));
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : read_word;
      pslverr <= !addr_ok;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg1 <= CFG1_RESET;
      cfg2 <= CFG2_RESET;
    end
    else if (wr_en && paddr == ADDR_CFG1)
      cfg1 <= pwdata[7:0];
    else if (wr_en && paddr == ADDR_CFG2)
      cfg2 <= pwdata[10:0];
  end

  // ---------------- transmit buffers and aborts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req        <= '0;
      abt        <= '0;
      larb       <= '0;
      fault      <= '0;
      abort_pend <= '0;
      done       <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_BUFS; i++)
      begin
        // done flags are write-one-to-clear; a completion in the same cycle wins
        if (wr_en && paddr == ADDR_INTF && pwdata[INTF_DONE_LSB + i])
          done[i] <= 1'b0;
        if (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_ABORT_ALL_BIT] && req[i])
          abort_pend[i] <= 1'b1;
        if (wr_en && paddr == ADDR_TXCON0 + 8'(4 * i))
        begin
          if (pwdata[TXCON_REQ_BIT] && !req[i])
          begin
            req[i]        <= 1'b1;
            abt[i]        <= 1'b0;
            larb[i]       <= 1'b0;
            fault[i]      <= 1'b0;
            abort_pend[i] <= 1'b0;
          end
          else if (!pwdata[TXCON_REQ_BIT] && req[i])
            abort_pend[i] <= 1'b1;
        end
        if (tx_active && tx_buf == 2'(i))
        begin
          if (tx_success)
          begin
            // a finished frame cannot be taken back; the abort is dropped
            req[i]        <= 1'b0;
            done[i]       <= 1'b1;
            abort_pend[i] <= 1'b0;
          end
          else if (tx_lost_arb || any_err)
          begin
            larb[i]  <= tx_lost_arb;
            fault[i] <= any_err;
            if (abort_pend[i])
            begin
              req[i]        <= 1'b0;
              abt[i]        <= 1'b1;
              abort_pend[i] <= 1'b0;
            end
          end
        end
        else if (abort_pend[i])
        begin
          req[i]        <= 1'b0;
          abt[i]        <= 1'b1;
          abort_pend[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------- transmit error counter
  assign any_err = tx_active && (ack_error || form_error || bit_error);
  assign next_tec = (any_err && tec != 9'h1ff) ? tec + 9'h001 : tec;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec       <= 9'h000;
      err_state <= ERR_ACTIVE;
      sum_flag  <= 1'b0;
      warn_flag <= 1'b0;
      pass_flag <= 1'b0;
      boff_flag <= 1'b0;
    end
    else
    begin
      tec <= next_tec;
      if (wr_en && paddr == ADDR_INTF)
      begin
        if (pwdata[INTF_ERR_SUM_BIT])
          sum_flag <= 1'b0;
        if (pwdata[INTF_TX_WARN_BIT])
          warn_flag <= 1'b0;
        if (pwdata[INTF_TX_PASS_BIT])
          pass_flag <= 1'b0;
        if (pwdata[INTF_BUS_OFF_BIT])
          boff_flag <= 1'b0;
      end
      // flags follow next_tec so they rise on the crossing edge itself
      if (tec <= WARN_LIMIT && next_tec > WARN_LIMIT)
      begin
        warn_flag <= 1'b1;
        sum_flag  <= 1'b1;
      end
      if (tec <= PASSIVE_LIMIT && next_tec > PASSIVE_LIMIT)
      begin
        pass_flag <= 1'b1;
        sum_flag  <= 1'b1;
        err_state <= ERR_PASSIVE;
      end
      if (tec <= BUS_OFF_LIMIT && next_tec > BUS_OFF_LIMIT)
      begin
        boff_flag <= 1'b1;
        sum_flag  <= 1'b1;
        err_state <= ERR_BUS_OFF;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_pending <= '0;
      tx_irq     <= 1'b0;
      err_irq    <= 1'b0;
      bus_off    <= 1'b0;
    end
    else
    begin
      tx_pending <= req & ~abort_pend;
      tx_irq     <= |done;
      err_irq    <= sum_flag;
      bus_off    <= (err_state == ERR_BUS_OFF);
    end
  end

  // ---------------- bit timing
  logic [5:0] pre_cnt;
  logic       half_tick;
  logic       half_phase;
  logic       tq_tick;
  logic [5:0] prop_len;
  logic [5:0] ph1_len;
  logic [5:0] ph2_base;
  logic [5:0] ph2_pad;
  logic [5:0] ph2_len;
  logic [5:0] jump_len;
  logic [5:0] nom_len;
  seg_t       seg;
  logic [5:0] seg_cnt;
  logic [5:0] pos;
  logic [5:0] ph1_ext;
  logic       synced;
  logic       rx_prev;
  logic       fall_edge;
  logic [1:0] hist;
  logic       vote;

  assign prop_len = {3'b000, cfg2[CFG2_PROP_LSB +: 3]} + 6'h01;
  assign ph1_len  = {3'b000, cfg2[CFG2_PH1_LSB +: 3]} + 6'h01;
  assign jump_len = {4'b0000, cfg1[CFG1_JUMP_LSB +: 2]} + 6'h01;
  assign ph2_base = cfg2[CFG2_PH2_FREE_BIT] ? {3'b000, cfg2[CFG2_PH2_LSB +: 3]} + 6'h01
                  : (ph1_len > INFO_PROC_TQ ? ph1_len : INFO_PROC_TQ);
  // short settings are stretched in phase two so a bit never drops below 8 quanta
  assign ph2_pad  = (6'h01 + prop_len + ph1_len + ph2_base < MIN_BIT_TQ)
                  ? MIN_BIT_TQ - 6'h01 - prop_len - ph1_len : ph2_base;
  assign ph2_len  = ph2_pad;
  assign nom_len  = 6'h01 + prop_len + ph1_len + ph2_len;
  assign fall_edge = rx_prev && !rx_level;
  assign vote = (rx_level & hist[0]) | (rx_level & hist[1]) | (hist[0] & hist[1]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt    <= 6'h00;
      half_tick  <= 1'b0;
      half_phase <= 1'b0;
    end
    else if (fall_edge && bus_idle)
    begin
      pre_cnt    <= 6'h00;
      half_tick  <= 1'b0;
      half_phase <= 1'b0;
    end
    else if (pre_cnt == cfg1[CFG1_PRESCALER_LSB +: 6])
    begin
      pre_cnt    <= 6'h00;
      half_tick  <= 1'b1;
      half_phase <= !half_phase;
    end
    else
    begin
      pre_cnt   <= pre_cnt + 6'h01;
      half_tick <= 1'b0;
    end
  end

  // a quantum ends on every second half tick: fixed divide by two
  assign tq_tick = half_tick && !half_phase;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seg     <= SEG_SYNC;
      seg_cnt <= 6'h01;
      pos     <= 6'h00;
      ph1_ext <= 6'h00;
      synced  <= 1'b0;
      rx_prev <= 1'b1;
      bit_start <= 1'b0;
    end
    else
    begin
      rx_prev   <= rx_level;
      bit_start <= 1'b0;
      if (fall_edge && bus_idle)
      begin
        seg     <= SEG_SYNC;
        seg_cnt <= 6'h01;
        pos     <= 6'h00;
        ph1_ext <= 6'h00;
        synced  <= 1'b1;
      end
      else if (fall_edge && !synced && seg != SEG_SYNC)
      begin
        synced <= 1'b1;
        // late edge stretches phase one, early edge cuts phase two
        if (seg == SEG_PH2)
          seg_cnt <= (seg_cnt > jump_len) ? seg_cnt - jump_len : 6'h01;
        else if (seg == SEG_PH1)
          seg_cnt <= seg_cnt + (pos < jump_len ? pos : jump_len);
        else
          ph1_ext <= (pos < jump_len) ? pos : jump_len;
      end
      else if (tq_tick)
      begin
        pos <= pos + 6'h01;
        if (seg_cnt == 6'h01)
        begin
          case (seg)
            SEG_SYNC:
            begin
              seg     <= SEG_PROP;
              seg_cnt <= prop_len;
            end
            SEG_PROP:
            begin
              seg     <= SEG_PH1;
              seg_cnt <= ph1_len + ph1_ext;
            end
            SEG_PH1:
            begin
              seg     <= SEG_PH2;
              seg_cnt <= ph2_len;
            end
            default:
            begin
              seg       <= SEG_SYNC;
              seg_cnt   <= 6'h01;
              pos       <= 6'h00;
              ph1_ext   <= 6'h00;
              synced    <= 1'b0;
              bit_start <= 1'b1;
            end
          endcase
        end
        else
          seg_cnt <= seg_cnt - 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist         <= 2'b11;
      sample_valid <= 1'b0;
      sample_bit   <= 1'b1;
    end
    else
    begin
      if (half_tick)
        hist <= {hist[0], rx_level};
      sample_valid <= 1'b0;
      if (tq_tick && seg == SEG_PH1 && seg_cnt == 6'h01)
      begin
        sample_valid <= 1'b1;
        sample_bit   <= cfg2[CFG2_VOTE_BIT] ? vote : rx_level;
      end
    end
  end

  // ---------------- checks
  a_warn_cross: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tec) <= WARN_LIMIT && tec > WARN_LIMIT) |-> (warn_flag && sum_flag))
    else $error("warning flag missed its crossing");
  a_pass_cross: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tec) <= PASSIVE_LIMIT && tec > PASSIVE_LIMIT) |-> (pass_flag && err_state != ERR_ACTIVE))
    else $error("error-passive not entered");
  a_boff_cross: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tec) <= BUS_OFF_LIMIT && tec > BUS_OFF_LIMIT) |-> ##1 (bus_off && boff_flag))
    else $error("bus-off not entered");
  a_tec_step: assert property (@(posedge pclk) disable iff (!presetn)
    (any_err && tec < 9'h1ff) |=> (tec == $past(tec) + 9'h001))
    else $error("error counter did not step by one");
  a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (abort_pend[0] && !(tx_active && tx_buf == 2'd0)) |=> (abt[0] && !req[0] && !$rose(done[0])))
    else $error("idle abort not processed");
  a_req_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TXCON0 && pwdata[TXCON_REQ_BIT] && !req[0]
     && !(tx_active && tx_buf == 2'd0)) |=> (req[0] && !abt[0] && !larb[0] && !fault[0]))
    else $error("request did not clear status flags");
  a_bit_len: assert property (@(posedge pclk) disable iff (!presetn)
    nom_len >= MIN_BIT_TQ && nom_len <= MAX_BIT_TQ)
    else $error("nominal bit length out of range");
  a_sample_vote: assert property (@(posedge pclk) disable iff (!presetn)
    (tq_tick && seg == SEG_PH1 && seg_cnt == 6'h01 && cfg2[CFG2_VOTE_BIT])
    |=> (sample_valid && sample_bit == $past(vote)))
    else $error("majority sample wrong");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule
`default_nettype wire

// ===== rtl/can_tx_pkg.sv
// constants and types for the transmit control and bit timing block
// Behaviour
// - clearing a buffer request aborts its message
// - abort-all bit 12 aborts every pending buffer
// - abort only before start or after loss/error
// - abort sets aborted flag, not done flag
// - ack, form, bit errors add one
// - count above 96 sets warning and summary
// - interrupt while a buffer is free; flags per buffer; tx_irq follows the done flags, set only by a successful send
// - summary flag plus individual cause bits
// - count above 127 sets error-passive state
// - count above 255 sets bus-off state
// - four segments, 8 to 25 quanta per bit
// - quantum is 2*(prescaler+1) module clocks
// - propagation 1 to 8 quanta, bits 2:0
// - phase one bits 5:3, phase two bits 10:8
// - phase two programmed or max(phase one, 2)
// - sample at phase one end, optional 2-of-3 vote
// - edges adjust phase one and phase two
// - setting request clears abort, loss, fault flags
// - jump width 1 to 4 quanta, bits 7:6
package can_tx_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INTF   = 8'h04;
  localparam logic [7:0] ADDR_CFG1   = 8'h08;
  localparam logic [7:0] ADDR_CFG2   = 8'h0c;
  localparam logic [7:0] ADDR_TXCON0 = 8'h10;
  localparam logic [7:0] ADDR_TEC    = 8'h1c;
  localparam int CTRL_ABORT_ALL_BIT = 12;
  localparam int INTF_DONE_LSB      = 0;
  localparam int INTF_ERR_SUM_BIT   = 5;
  localparam int INTF_TX_WARN_BIT   = 10;
  localparam int INTF_TX_PASS_BIT   = 12;
  localparam int INTF_BUS_OFF_BIT   = 13;
  localparam int CFG1_PRESCALER_LSB = 0;
  localparam int CFG1_JUMP_LSB      = 6;
  localparam int CFG2_PROP_LSB      = 0;
  localparam int CFG2_PH1_LSB       = 3;
  localparam int CFG2_VOTE_BIT      = 6;
  localparam int CFG2_PH2_FREE_BIT  = 7;
  localparam int CFG2_PH2_LSB       = 8;
  localparam int TXCON_REQ_BIT      = 3;
  localparam int TXCON_FAULT_BIT    = 4;
  localparam int TXCON_LARB_BIT     = 5;
  localparam int TXCON_ABT_BIT      = 6;
  localparam int TXCON_ACTIVE_BIT   = 7;
  localparam logic [10:0] CFG2_RESET = 11'h000;
  localparam logic [7:0]  CFG1_RESET = 8'h00;
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
  localparam logic [5:0] MIN_BIT_TQ    = 6'h08;
  localparam logic [5:0] MAX_BIT_TQ    = 6'h19;
  localparam logic [5:0] INFO_PROC_TQ  = 6'h02;
  typedef enum logic [1:0] {ERR_ACTIVE, ERR_PASSIVE, ERR_BUS_OFF} err_state_t;
  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_t;
endpackage

// ===== tb/can_engine_model.sv
// far-side protocol engine and bus model driving the transmit status pins
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
  // clock
  input  wire logic       pclk,
  // engine side of the block
  input  wire logic [2:0] tx_pending,
  output logic            tx_active,
  output logic [1:0]      tx_buf,
  output logic            tx_success,
  output logic            tx_lost_arb,
  output logic            ack_error,
  output logic            form_error,
  output logic            bit_error,
  output logic            bus_idle,
  output logic            rx_level
);
  initial
  begin
    tx_active = 1'b0;
    tx_buf = 2'h0;
    tx_success = 1'b0;
    tx_lost_arb = 1'b0;
    ack_error = 1'b0;
    form_error = 1'b0;
    bit_error = 1'b0;
    bus_idle = 1'b0;
    rx_level = 1'b1;
  end
  // an attempt starts only for a queued buffer, after lag cycles
  task automatic start(input logic [1:0] b, input int lag);
    repeat (lag) @(posedge pclk);
    if (tx_pending[b] === 1'b1)
    begin
      tx_active <= 1'b1;
      tx_buf <= b;
    end
  endtask
  // kind 0 success, 1 lost arbitration, 2 ack, 3 form, 4 bit error; held n cycles
  task automatic event_pulse(input int kind, input int n);
    @(posedge pclk);
    tx_success <= (kind == 0);
    tx_lost_arb <= (kind == 1);
    ack_error <= (kind == 2);
    form_error <= (kind == 3);
    bit_error <= (kind == 4);
    repeat (n) @(posedge pclk);
    tx_success <= 1'b0;
    tx_lost_arb <= 1'b0;
    ack_error <= 1'b0;
    form_error <= 1'b0;
    bit_error <= 1'b0;
  endtask
  task automatic finish();
    @(posedge pclk);
    tx_active <= 1'b0;
  endtask
  task automatic level(input logic v);
    @(posedge pclk);
    rx_level <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/can_tx_ctrl_test.sv
// self-checking bench for transmit abort, error counting and bit timing
`timescale 1ns/1ps
`default_nettype none
module can_tx_ctrl_test;
  import can_tx_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_active;
  logic [1:0]  tx_buf;
  logic        tx_success;
  logic        tx_lost_arb;
  logic        ack_error;
  logic        form_error;
  logic        bit_error;
  logic        bus_idle;
  logic [2:0]  tx_pending;
  logic        rx_level;
  logic        sample_valid;
  logic        sample_bit;
  logic        bit_start;
  logic        tx_irq;
  logic        err_irq;
  logic        bus_off;
  int          miscompares = 0;
  int          num_checks = 0;

  can_tx_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_active(tx_active), .tx_buf(tx_buf), .tx_success(tx_success),
    .tx_lost_arb(tx_lost_arb), .ack_error(ack_error), .form_error(form_error),
    .bit_error(bit_error), .bus_idle(bus_idle), .tx_pending(tx_pending),
    .rx_level(rx_level), .sample_valid(sample_valid), .sample_bit(sample_bit),
    .bit_start(bit_start), .tx_irq(tx_irq), .err_irq(err_irq), .bus_off(bus_off));
  can_engine_model eng (.pclk(pclk), .tx_pending(tx_pending), .tx_active(tx_active),
    .tx_buf(tx_buf), .tx_success(tx_success), .tx_lost_arb(tx_lost_arb),
    .ack_error(ack_error), .form_error(form_error), .bit_error(bit_error),
    .bus_idle(bus_idle), .rx_level(rx_level));

  always #12.5 pclk = ~pclk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd_chk(ADDR_CFG1, 32'hff, 32'h0);
    rd_chk(ADDR_CFG2, 32'h7ff, 32'h0);
    rd_chk(ADDR_TEC, 32'h1ff, 32'h0);
    wr(ADDR_CFG1, 32'hc5);
    rd_chk(ADDR_CFG1, 32'hffffffff, 32'hc5);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
  endtask
  task automatic t_abort_idle();
    wr(ADDR_INTF, 32'h7);
    wr(ADDR_TXCON0, 32'h8);
    repeat (2) @(posedge pclk);
    chk(32'(tx_pending), 32'h1);
    rd_chk(ADDR_TXCON0, 32'h78, 32'h08);
    wr(ADDR_TXCON0, 32'h0);
    rd_chk(ADDR_TXCON0, 32'h48, 32'h40);
    rd_chk(ADDR_INTF, 32'h7, 32'h0);
    chk(32'(tx_pending), 32'h0);
    wr(ADDR_TXCON0, 32'h8);
    rd_chk(ADDR_TXCON0, 32'h48, 32'h08);
  endtask
  task automatic t_success();
    eng.start(2'd0, 2);
    eng.event_pulse(0, 1);
    eng.finish();
    rd_chk(ADDR_TXCON0, 32'h8, 32'h0);
    rd_chk(ADDR_INTF, 32'h7, 32'h1);
    chk(32'(tx_irq), 32'h1);
  endtask
  task automatic t_abort_all();
    wr(8'h14, 32'h8);
    wr(8'h18, 32'h8);
    eng.start(2'd1, 2);
    wr(ADDR_CTRL, 32'h1000);
    rd_chk(8'h18, 32'h48, 32'h40);
    rd_chk(8'h14, 32'h48, 32'h08);
    rd_chk(ADDR_CTRL, 32'h1000, 32'h1000);
    eng.event_pulse(1, 1);
    eng.finish();
    rd_chk(8'h14, 32'h68, 32'h60);
    rd_chk(ADDR_CTRL, 32'h1000, 32'h0);
    rd_chk(ADDR_INTF, 32'h6, 32'h0);
  endtask
  task automatic measure(output int s, output int b);
    int c;
    c = 0;
    while (bit_start !== 1'b1 && c < 400)
    begin
      @(posedge pclk);
      c++;
    end
    s = 0;
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
      if (sample_valid === 1'b1)
        s = c;
    end
    while (bit_start !== 1'b1 && c < 400);
    b = c;
  endtask
  task automatic t_timing();
    int p [3] = '{1, 0, 3};
    int pr [3] = '{2, 8, 1};
    int p1 [3] = '{4, 8, 1};
    int fr [3] = '{1, 0, 0};
    int p2 [3] = '{3, 1, 1};
    int ph;
    int tot;
    int tq;
    int s;
    int b;
    // each set keeps bit >= 1 us and ph2 > jump width; only the first two keep prop+ph1 >= ph2 and sample near 70 percent
    for (int i = 0; i < 3; i++)
    begin
      ph = (fr[i] == 1) ? p2[i] : ((p1[i] > 2) ? p1[i] : 2);
      tot = 1 + pr[i] + p1[i] + ph;
      if (tot < 8)
        tot = 8;
      tq = 2 * (p[i] + 1);
      wr(ADDR_CFG1, 32'(p[i]));
      wr(ADDR_CFG2, 32'(pr[i] - 1 + (p1[i] - 1) * 8 + fr[i] * 128 + (p2[i] - 1) * 256));
      measure(s, b);
      measure(s, b);
      chk(32'(s), 32'(tq * (1 + pr[i] + p1[i])));
      chk(32'(b), 32'(tq * tot));
    end
  endtask
  task automatic t_vote();
    int s;
    int b;
    wr(ADDR_CFG1, 32'h1);
    wr(ADDR_CFG2, 32'h2d9);
    eng.level(1'b0);
    repeat (3) measure(s, b);
    chk(32'(sample_bit), 32'h0);
    eng.level(1'b1);
    repeat (3) measure(s, b);
    chk(32'(sample_bit), 32'h1);
  endtask
  // bus-off is left only by reset, so this runs last
  task automatic t_errors();
    wr(ADDR_TXCON0, 32'h8);
    eng.start(2'd0, 2);
    wr(ADDR_TXCON0, 32'h0);
    rd_chk(ADDR_TXCON0, 32'h48, 32'h08);
    eng.event_pulse(4, 96);
    rd_chk(ADDR_TXCON0, 32'h58, 32'h50);
    rd_chk(ADDR_TEC, 32'h1ff, 32'd96);
    rd_chk(ADDR_INTF, 32'h3420, 32'h0);
    eng.event_pulse(2, 1);
    rd_chk(ADDR_INTF, 32'h3420, 32'h0420);
    chk(32'(err_irq), 32'h1);
    eng.event_pulse(3, 30);
    rd_chk(ADDR_INTF, 32'h3420, 32'h0420);
    eng.event_pulse(4, 1);
    rd_chk(ADDR_INTF, 32'h3420, 32'h1420);
    eng.event_pulse(2, 127);
    rd_chk(ADDR_TEC, 32'h1ff, 32'd255);
    chk(32'(bus_off), 32'h0);
    eng.event_pulse(3, 1);
    rd_chk(ADDR_INTF, 32'h3420, 32'h3420);
    chk(32'(bus_off), 32'h1);
    eng.finish();
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_abort_idle();
    t_success();
    t_abort_all();
    t_timing();
    t_vote();
    t_errors();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
